// >>> verilog/icc_capture.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Stop-in-idle bit halts capture during Idle; the mode 111 wake interrupt still fires.
// - Timebase bit picks timer two or three.
// - Interrupt every one to four captures.
// - Overflow flag reads one after overflow.
// - Buffer status bit shows unread captures.
// - Mode 000 turns capture off.
// - 011 rising edges, 010 falling edges.
// - 100 every 4th, 101 every 16th rise.
// - Mode 110 stops capture; unlike 000 it does not clear overflow.
// - Mode 111: rising-edge wake interrupt in Sleep/Idle.
// - Both-edge mode 001 ignores interrupt count.
// - Control bits 15-14, 12-8 read zero.
// - Status bits write-one-to-clear, zero after reset.
module icc_capture (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        capture_pin,
    input  wire logic [15:0] timer_two_count,
    input  wire logic [15:0] timer_three_count,
    input  wire logic        cpu_idle,
    input  wire logic        cpu_sleep,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq
);
    logic [15:0] ctrl_ff;
    logic [2:0]  status_ff;
    logic [2:0]  mask_ff;
    logic        ovf_ff;
    logic [1:0]  cpi_cnt_ff;
    logic [3:0]  presc_ff;
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        irq_ff;
    logic        rise;
    logic        fall;
    logic [2:0]  mode;
    logic        halted;
    logic        edge_hit;
    logic        capture_evt;
    logic        irq_evt;
    logic        wake_evt;
    logic        fifo_full;
    logic        fifo_empty;
    logic [15:0] fifo_data;
    logic [15:0] stamp;
    logic        addr_phase;
    logic        rd_pop;
    logic [15:0] ctrl_view;
    logic [1:0]  nxt_cpi_cnt;

    assign mode   = ctrl_ff[icc_pkg::MODE_LSB +: 3];
    assign halted = ctrl_ff[icc_pkg::IDLE_BIT] & cpu_idle;

    icc_edge_detect u_edge (
        .core_clk   (core_clk),
        .reset      (reset),
        .pin_in     (capture_pin),
        .rise_pulse (rise),
        .fall_pulse (fall)
    );

    // Prescaler for the every-4th and every-16th rising edge modes.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            presc_ff <= 4'h0;
        end else if (mode != icc_pkg::MODE_RISE4 && mode != icc_pkg::MODE_RISE16) begin
            presc_ff <= 4'h0;
        end else if (rise && !halted) begin
            presc_ff <= presc_ff + 4'h1;
        end
    end

    always_comb begin
        case (mode)
            icc_pkg::MODE_BOTH:   edge_hit = rise | fall;
            icc_pkg::MODE_FALL:   edge_hit = fall;
            icc_pkg::MODE_RISE:   edge_hit = rise;
            icc_pkg::MODE_RISE4:  edge_hit = rise & (presc_ff[1:0] == icc_pkg::PRESC4_LAST[1:0]);
            icc_pkg::MODE_RISE16: edge_hit = rise & (presc_ff == icc_pkg::PRESC16_LAST);
            default:              edge_hit = 1'b0;
        endcase
    end

    assign capture_evt = edge_hit & ~halted;
    // Mode 111 ignores the stop-in-idle bit and every other control field.
    assign wake_evt = (mode == icc_pkg::MODE_WAKE) & rise & (cpu_sleep | cpu_idle);
    assign stamp = ctrl_ff[icc_pkg::TSEL_BIT] ? timer_two_count : timer_three_count;

    // Interrupt decimation counter; restarts in modes 000 and 110, holds while halted or in mode 111.
    always_comb begin
        nxt_cpi_cnt = cpi_cnt_ff;
        irq_evt     = 1'b0;
        if (capture_evt) begin
            if (mode == icc_pkg::MODE_BOTH) begin
                irq_evt = 1'b1;
            end else if (cpi_cnt_ff == ctrl_ff[icc_pkg::CPI_LSB +: 2]) begin
                irq_evt     = 1'b1;
                nxt_cpi_cnt = 2'h0;
            end else begin
                nxt_cpi_cnt = cpi_cnt_ff + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cpi_cnt_ff <= 2'h0;
        end else if (mode == icc_pkg::MODE_OFF || mode == icc_pkg::MODE_UNUSED) begin
            cpi_cnt_ff <= 2'h0;
        end else begin
            cpi_cnt_ff <= nxt_cpi_cnt;
        end
    end

    // AHB-Lite decode: the slave never stalls, so every transfer completes in zero waits.
    assign addr_phase = hsel & hready & htrans[1];
    assign rd_pop = addr_phase & ~hwrite & (haddr[7:0] == icc_pkg::BUF_OFS);

    icc_fifo u_fifo (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (capture_evt & ~fifo_full),
        .wr_data  (stamp),
        .rd_en    (rd_pop),
        .rd_data  (fifo_data),
        .full     (fifo_full),
        .empty    (fifo_empty)
    );

    // Overflow sticks until the buffer drains or the channel is turned off.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ovf_ff <= 1'b0;
        end else if (capture_evt && fifo_full) begin
            ovf_ff <= 1'b1;
        end else if (mode == icc_pkg::MODE_OFF || fifo_empty) begin
            ovf_ff <= 1'b0;
        end
    end

    always_comb begin
        ctrl_view = ctrl_ff & icc_pkg::CTRL_WMASK;
        // The flag register clears one cycle after the queue drains, so gate it here.
        ctrl_view[icc_pkg::OVF_BIT] = ovf_ff & ~fifo_empty;
        ctrl_view[icc_pkg::BNE_BIT] = ~fifo_empty;
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end else begin
            wr_pend_ff <= addr_phase & hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Control and mask registers are only written through the data-phase write path.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_ff <= icc_pkg::CTRL_RST;
            mask_ff <= icc_pkg::EVT_RST;
        end else if (wr_pend_ff) begin
            if (wr_addr_ff == icc_pkg::CTRL_OFS) begin
                ctrl_ff <= hwdata[15:0] & icc_pkg::CTRL_WMASK;
            end
            if (wr_addr_ff == icc_pkg::MASK_OFS) begin
                mask_ff <= hwdata[2:0];
            end
        end
    end

    // A new event in the same cycle as its write-one-to-clear keeps the bit set.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_ff <= icc_pkg::EVT_RST;
        end else begin
            status_ff <= (status_ff
                          & ~((wr_pend_ff && wr_addr_ff == icc_pkg::STAT_OFS)
                              ? hwdata[2:0] : 3'h0))
                         | {capture_evt & fifo_full, wake_evt, irq_evt};
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // Read data is registered at the address phase and shown in the data phase.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                icc_pkg::CTRL_OFS: hrdata_ff <= {16'h0000, ctrl_view};
                icc_pkg::BUF_OFS:  hrdata_ff <= {16'h0000, fifo_data};
                icc_pkg::STAT_OFS: hrdata_ff <= {29'h0000_0000, status_ff};
                icc_pkg::MASK_OFS: hrdata_ff <= {29'h0000_0000, mask_ff};
                default:           hrdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = irq_ff;
endmodule : icc_capture

// >>> verilog/icc_pkg.sv
package icc_pkg;
    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  BUF_OFS      = 8'h04;
    localparam logic [7:0]  STAT_OFS     = 8'h08;
    localparam logic [7:0]  MASK_OFS     = 8'h0C;
    // Control register field positions.
    localparam int          IDLE_BIT     = 13;
    localparam int          TSEL_BIT     = 7;
    localparam int          CPI_LSB      = 5;
    localparam int          OVF_BIT      = 4;
    localparam int          BNE_BIT      = 3;
    localparam int          MODE_LSB     = 0;
    localparam logic [15:0] CTRL_RST     = 16'h0000;
    localparam logic [15:0] CTRL_WMASK   = 16'h20E7;
    // Status bits: 0 capture interrupt, 1 wake interrupt, 2 overflow event.
    localparam int          NUM_EVT      = 3;
    localparam logic [2:0]  EVT_RST      = 3'h0;
    localparam int          FIFO_DEPTH   = 4;
    localparam logic [2:0]  MODE_OFF     = 3'h0;
    localparam logic [2:0]  MODE_BOTH    = 3'h1;
    localparam logic [2:0]  MODE_FALL    = 3'h2;
    localparam logic [2:0]  MODE_RISE    = 3'h3;
    localparam logic [2:0]  MODE_RISE4   = 3'h4;
    localparam logic [2:0]  MODE_RISE16  = 3'h5;
    localparam logic [2:0]  MODE_UNUSED  = 3'h6;
    localparam logic [2:0]  MODE_WAKE    = 3'h7;
    localparam logic [3:0]  PRESC4_LAST  = 4'h3;
    localparam logic [3:0]  PRESC16_LAST = 4'hF;
endpackage : icc_pkg

// >>> verilog/icc_edge_detect.sv
`timescale 1ns/1ps
// Two-flop synchroniser followed by an edge detector on the second stage only.
module icc_edge_detect (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic pin_in,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    logic meta_ff;
    logic sync_ff;
    logic prev_ff;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            prev_ff <= sync_ff;
        end
    end

    assign rise_pulse = sync_ff & ~prev_ff;
    assign fall_pulse = ~sync_ff & prev_ff;
endmodule : icc_edge_detect

// >>> verilog/icc_fifo.sv
`timescale 1ns/1ps
// Small capture buffer: oldest entry shown on rd_data while not empty.
module icc_fifo (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_en,
    output logic [15:0]      rd_data,
    output logic             full,
    output logic             empty
);
    logic [15:0] mem [icc_pkg::FIFO_DEPTH];
    logic [1:0]  wp_ff;
    logic [1:0]  rp_ff;
    logic [2:0]  cnt_ff;
    logic        do_wr;
    logic        do_rd;

    assign full  = (cnt_ff == 3'(icc_pkg::FIFO_DEPTH));
    assign empty = (cnt_ff == 3'h0);
    assign do_wr = wr_en & ~full;
    assign do_rd = rd_en & ~empty;
    assign rd_data = mem[rp_ff];

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wp_ff] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wp_ff  <= 2'h0;
            rp_ff  <= 2'h0;
            cnt_ff <= 3'h0;
        end else begin
            if (do_wr) begin
                wp_ff <= wp_ff + 2'h1;
            end
            if (do_rd) begin
                rp_ff <= rp_ff + 2'h1;
            end
            cnt_ff <= cnt_ff + 3'(do_wr) - 3'(do_rd);
        end
    end
endmodule : icc_fifo

// >>> tb/icc_monitor.sv
`timescale 1ns/1ps
module icc_monitor (
    input wire logic        core_clk,
    input wire logic        reset,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq
);
    logic        take;
    logic        wph_ff;
    logic [7:0]  wofs_ff;
    logic [15:0] ctl_ff;
    logic [2:0]  msk_ff;
    assign take = hsel && hready && htrans[1];
    // Shadows follow the write data phase so they change on the same edge as the design.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wph_ff  <= 1'b0;
            wofs_ff <= 8'h00;
            ctl_ff  <= icc_pkg::CTRL_RST;
            msk_ff  <= 3'h0;
        end else begin
            wph_ff  <= take && hwrite;
            wofs_ff <= haddr[7:0];
            if (wph_ff && wofs_ff == icc_pkg::CTRL_OFS)
                ctl_ff <= hwdata[15:0] & icc_pkg::CTRL_WMASK;
            if (wph_ff && wofs_ff == icc_pkg::MASK_OFS)
                msk_ff <= hwdata[2:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_rd(ofs);
        take && !hwrite && haddr[7:0] == ofs;
    endsequence
    sequence s_off_rd;
        (ctl_ff[2:0] == icc_pkg::MODE_OFF) [*2] ##0 s_rd(icc_pkg::CTRL_OFS);
    endsequence
    property p_rsvd;
        s_rd(icc_pkg::CTRL_OFS) |=> hrdata[31:14] == 18'h0_0000 && hrdata[12:8] == 5'h00;
    endproperty
    property p_rwf;
        s_rd(icc_pkg::CTRL_OFS) |=> (hrdata[15:0] & icc_pkg::CTRL_WMASK) == $past(ctl_ff);
    endproperty
    property p_ovf;
        s_rd(icc_pkg::CTRL_OFS) |=> !hrdata[4] || hrdata[3];
    endproperty
    property p_off;
        s_off_rd |=> !hrdata[4];
    endproperty
    property p_irq;
        irq |-> $past(msk_ff) != 3'h0;
    endproperty
    property p_hold;
        !(take && !hwrite) |=> $stable(hrdata);
    endproperty
    property p_unmap;
        take && !hwrite && haddr[7:0] > icc_pkg::MASK_OFS |=> hrdata == 32'h0000_0000;
    endproperty
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved control bits not zero");
    a_rwf: assert property (p_rwf) else $error("control readback wrong");
    a_ovf: assert property (p_ovf) else $error("overflow with empty buffer");
    a_off: assert property (p_off) else $error("overflow while off");
    a_irq: assert property (p_irq) else $error("irq with all masked");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule : icc_monitor
bind icc_capture icc_monitor icc_monitor_i (.core_clk, .reset, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq);

// >>> tb/icc_pin_model.sv
`timescale 1ns/1ps
module icc_pin_model (
    input wire logic core_clk,
    output logic     pin
);
    initial pin = 1'b0;
    // Each level is held four clocks so the two-flop synchroniser sees every edge.
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge core_clk);
            pin <= 1'b1;
            repeat (4) @(posedge core_clk);
            pin <= 1'b0;
        end
    endtask : pulses
endmodule : icc_pin_model

// >>> tb/icc_capture_tb.sv
`timescale 1ns/1ps
module icc_capture_tb;
    logic        core_clk = 1'b0;
    logic        reset, capture_pin, cpu_idle, cpu_sleep, hsel, hwrite;
    logic        hready, hreadyout, hresp, irq;
    logic [15:0] timer_two_count, timer_three_count;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          seed = 32'hfc7f;
    always #4 core_clk = ~core_clk;
    assign hready = hreadyout;
    icc_capture icc_capture_i (.core_clk, .reset, .capture_pin, .timer_two_count,
        .timer_three_count, .cpu_idle, .cpu_sleep, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irq);
    icc_pin_model icc_pin_model_i (.core_clk, .pin(capture_pin));
    task automatic end_of_test;
        if (n_mismatch == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge core_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h00_0000, a};
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        q = hrdata;
    endtask : bus
    function automatic int events(input logic [2:0] m, input int n);
        case (m)
            3'h1: return 2 * n;
            3'h2, 3'h3: return n;
            3'h4: return n / 4;
            3'h5: return n / 16;
            default: return 0;
        endcase
    endfunction : events
    initial begin
        repeat (30000) @(posedge core_clk);
        n_mismatch++;
        end_of_test;
    end
    initial begin
        logic [31:0] q;
        logic [15:0] t2, t3;
        logic [2:0]  m, msk, st;
        logic [1:0]  cpi;
        logic        tsel, halt, idl, slp;
        int          ev;
        reset = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = 68'h0;
        {cpu_idle, cpu_sleep, timer_two_count, timer_three_count} = 34'h0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        bus(1'b0, icc_pkg::CTRL_OFS, 32'h0, q);
        chk(q, 32'h0000_0000);
        bus(1'b1, icc_pkg::CTRL_OFS, 32'hFFFF_FFFF, q);
        bus(1'b0, icc_pkg::CTRL_OFS, 32'h0, q);
        chk(q, 32'h0000_20E7);
        bus(1'b0, 8'h10, 32'h0, q);
        chk(q, 32'h0000_0000);
        // Round zero is the hand-picked corner: deepest decimation, idle without halt.
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 8; k++) begin
                m = k[2:0];
                cpi = (r == 0) ? 2'h3 : 2'($random(seed));
                {tsel, halt, idl, slp} = (r == 0) ? 4'h2 : 4'($random(seed));
                msk = 3'($random(seed));
                t2 = 16'($random(seed));
                t3 = 16'($random(seed));
                {cpu_idle, cpu_sleep, timer_two_count, timer_three_count} <= {idl, slp, t2, t3};
                bus(1'b1, icc_pkg::MASK_OFS, {29'h0, msk}, q);
                bus(1'b1, icc_pkg::CTRL_OFS, {18'h0, halt, 5'h0, tsel, cpi, 2'h0, m}, q);
                icc_pin_model_i.pulses(16);
                repeat (6) @(posedge core_clk);
                ev = (halt && idl) ? 0 : events(m, 16);
                st = {ev > 4, m == 3'h7 && (idl || slp), ev >= ((m == 3'h1) ? 1 : cpi + 1)};
                bus(1'b0, icc_pkg::CTRL_OFS, 32'h0, q);
                chk(q, {18'h0, halt, 5'h0, tsel, cpi, ev > 4, ev > 0, m});
                bus(1'b0, icc_pkg::STAT_OFS, 32'h0, q);
                chk(q, {29'h0, st});
                chk({31'h0, irq}, {31'h0, |(st & msk)});
                // Turning the channel off must drop the overflow flag but keep the queue.
                if (r == 2) begin
                    bus(1'b1, icc_pkg::CTRL_OFS, 32'h0, q);
                    bus(1'b0, icc_pkg::CTRL_OFS, 32'h0, q);
                    chk(q, {28'h0, ev > 0, 3'h0});
                end
                for (int i = 0; i < 4 && i < ev; i++) begin
                    bus(1'b0, icc_pkg::BUF_OFS, 32'h0, q);
                    chk(q, {16'h0, tsel ? t2 : t3});
                end
                bus(1'b0, icc_pkg::CTRL_OFS, 32'h0, q);
                chk({30'h0, q[4:3]}, 32'h0);
                bus(1'b1, icc_pkg::STAT_OFS, 32'h7, q);
                bus(1'b1, icc_pkg::CTRL_OFS, 32'h0, q);
                bus(1'b0, icc_pkg::STAT_OFS, 32'h0, q);
                chk(q | {31'h0, irq}, 32'h0);
            end
        end
        end_of_test;
    end
endmodule : icc_capture_tb
